/* File: cpu_slice_pkg.sv */
/*
  Shared constants for the shift/logic/subtract execution slice:
  opcodes, flag positions, reset values and state encodings.
  Assumes nothing of its surroundings.
*/
package cpu_slice_pkg;
  localparam logic [7:0] OP_CARRY_SET = 8'h37;
  localparam logic [7:0] OP_SUB_IMM   = 8'hd6;
  localparam logic [7:0] OP_XOR_IMM   = 8'hee;
  localparam logic [7:0] PFX_BIT      = 8'hcb;
  localparam logic [7:0] PFX_EXT      = 8'hed;
  localparam logic [7:0] PFX_IDX_LO   = 8'hdd;
  localparam logic [7:0] PFX_IDX_HI   = 8'hfd;
  localparam logic [7:0] OP_SLEEP     = 8'h76;
  localparam logic [7:0] OP_PORT_TEST = 8'h74;
  localparam logic [7:0] OP_TEST_IMM  = 8'h64;
  localparam logic [4:0] GRP_SUB      = 5'h12;
  localparam logic [4:0] GRP_XOR      = 5'h15;
  localparam logic [4:0] GRP_SHL      = 5'h04;
  localparam logic [4:0] GRP_SHA      = 5'h05;
  localparam logic [4:0] GRP_SHZ      = 5'h07;
  localparam logic [1:0] GRP_SET      = 2'h3;
  localparam logic [2:0] SEL_C        = 3'h1;
  localparam logic [2:0] SEL_H        = 3'h4;
  localparam logic [2:0] SEL_L        = 3'h5;
  localparam logic [2:0] SEL_MEM      = 3'h6;
  localparam logic [2:0] SEL_ACC      = 3'h7;
  localparam int FL_S  = 7;
  localparam int FL_Z  = 6;
  localparam int FL_H  = 4;
  localparam int FL_PV = 2;
  localparam int FL_N  = 1;
  localparam int FL_C  = 0;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [15:0] RST_SP    = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;

  typedef enum logic [6:0] {
    S_FETCH = 7'b0000001, S_RDMEM = 7'b0000010, S_WRMEM = 7'b0000100, S_RDIO = 7'b0001000,
    S_SLEEP = 7'b0010000, S_PUSH_HI = 7'b0100000, S_PUSH_LO = 7'b1000000
  } state_t;

  typedef enum logic [7:0] {
    P_NONE = 8'h01, P_CB = 8'h02, P_ED = 8'h04, P_IMM = 8'h08,
    P_TIO = 8'h10, P_IDX = 8'h20, P_IDXCB = 8'h40, P_IDXOP = 8'h80
  } pfx_t;

  typedef enum logic [1:0] {ALU_SUB = 2'h0, ALU_XOR = 2'h1, ALU_AND = 2'h2} alu_t;
endpackage

/* File: cpu_shift_logic_subtract_ops.sv */
/*
  Fetch/execute slice of an 8-bit core: word subtract with borrow, carry set,
  bit set, shifts, sleep, subtract, AND-test and exclusive-OR.
  Assumes a synchronous memory/port bus on mclk that returns read data by the
  end of the strobe clock; interrupt requests arrive asynchronously.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - word subtract with borrow: pointer pair minus pair minus carry; H from bit 11.
// - carry set: C=1, H=0, N=0, other flags kept, 2 clocks.
// - bit set register form CB 11bbbrrr: binary bit index, no flags, 4 clocks.
// - bit set indexed form: prefix, CB, displacement, 11bbb110; y picks index.
// - arithmetic left shift: zero into bit 0, bit 7 to carry, S Z P set.
// - sleep ED 76 raises sleep output, idles until interrupt, flags kept.
// - while asleep both address buses read zero and both write buses zero.
// - interrupt ending sleep pushes address of the following instruction.
// - masked interrupt request during sleep simply resumes at next instruction.
// - arithmetic right shift keeps bit 7, bit 0 to carry.
// - logical right shift: zero into bit 7, bit 0 to carry.
// - subtract from accumulator: H borrow bit 3, C borrow bit 7, V overflow.
// - AND-test with register, immediate or port: result not stored, H set.
// - exclusive-OR into accumulator, clears H, N, C.
module cpu_shift_logic_subtract_ops
  import cpu_slice_pkg::*;
#(
  parameter logic [15:0] NMI_VECTOR = 16'h0080,
  parameter logic [15:0] INT_VECTOR = 16'h0090
)(
  input  wire logic        mclk,               // 100 MHz clock
  input  wire logic        rst,                // synchronous reset, high
  input  wire logic [7:0]  mem_rdata,          // memory read data
  input  wire logic [7:0]  port_rdata,         // port read data
  input  wire logic        irq_pin,            // maskable request, async
  input  wire logic        nmi_pin,            // non-maskable request, async
  input  wire logic        int_enable,         // maskable interrupts enabled
  output logic      [15:0] memory_address_bus, // memory address
  output logic      [7:0]  memory_write_bus,   // memory write data
  output logic             mem_rd_strobe,      // memory read
  output logic             mem_wr_strobe,      // memory write
  output logic      [15:0] port_address_bus,   // port address
  output logic      [7:0]  port_write_bus,     // port write data
  output logic             port_rd_strobe,     // port read
  output logic             sleep_out,          // asleep
  output logic             int_ack_pulse,      // return address pushed
  output logic      [7:0]  acc_out,            // accumulator
  output logic      [7:0]  flags_out           // flag register
);
  state_t      state_reg;
  pfx_t        pfx_reg;
  alu_t        alu_reg, alu_op;
  logic        phase_reg, cb_mem_reg, idx_hi_reg, alu_fire;
  logic [7:0]  rf_reg [0:7];
  logic [7:0]  f_reg, op_reg, imm_reg, disp_reg, wdat_reg, alu_a, alu_b, cb_op, cb_v;
  logic [15:0] pc_reg, sp_reg, ea_reg, vec_reg, first_index_reg, second_index_reg, alu_q, cb_q, ss_val;
  logic [16:0] wsub;
  logic [12:0] wsub_lo;
  logic [2:0]  irq_sync, nmi_sync;
  logic        irq_lvl, nmi_lvl;
  wire  [15:0] pair_pointer = {rf_reg[SEL_H], rf_reg[SEL_L]};

  function automatic logic [15:0] alu8(input alu_t op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] nf;
    d = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    r = (op == ALU_SUB) ? d[7:0] : ((op == ALU_XOR) ? (a ^ b) : (a & b));
    nf = 8'h00;
    nf[FL_S] = r[7];
    nf[FL_Z] = (r == 8'h00);
    nf[FL_PV] = (op == ALU_SUB) ? ((a[7] ^ b[7]) & (a[7] ^ r[7])) : ~^r;
    nf[FL_H] = (op == ALU_SUB) ? h[4] : (op == ALU_AND);
    nf[FL_C] = (op == ALU_SUB) & d[8];
    return {nf, r};
  endfunction

  // other bit-prefix ops belong elsewhere; they pass the operand unchanged
  function automatic logic [15:0] cbop(input logic [7:0] op, input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] nf;
    logic       c;
    r = v;
    c = f[FL_C];
    case (op[7:3])
      GRP_SHL: {c, r} = {v, 1'b0};
      GRP_SHA: {r, c} = {v[7], v};
      GRP_SHZ: {r, c} = {1'b0, v};
      default: if (op[7:6] == GRP_SET) r = v | (8'h01 << op[5:3]);
    endcase
    nf = f;
    if (op[7:3] == GRP_SHL || op[7:3] == GRP_SHA || op[7:3] == GRP_SHZ)
    begin
      nf = 8'h00;
      nf[FL_S] = r[7];
      nf[FL_Z] = (r == 8'h00);
      nf[FL_PV] = ~^r;
      nf[FL_C] = c;
    end
    return {nf, r};
  endfunction

  assign acc_out = rf_reg[SEL_ACC];
  assign flags_out = f_reg;

  // 3-stage synchronisers; a level counts once stages 2 and 3 agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_sync <= 3'h0;
      nmi_sync <= 3'h0;
      irq_lvl <= 1'b0;
      nmi_lvl <= 1'b0;
    end
    else
    begin
      irq_sync <= {irq_sync[1:0], irq_pin};
      nmi_sync <= {nmi_sync[1:0], nmi_pin};
      if (irq_sync[1] == irq_sync[2]) irq_lvl <= irq_sync[2];
      if (nmi_sync[1] == nmi_sync[2]) nmi_lvl <= nmi_sync[2];
    end
  end

  // two-clock machine cycle: phase 0 sets up the bus, phase 1 samples and decides
  always_ff @(posedge mclk)
  begin
    if (rst) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg;
  end

  always_comb
  begin
    alu_fire = 1'b0;
    alu_op = alu_reg;
    alu_a = rf_reg[SEL_ACC];
    alu_b = mem_rdata;
    cb_op = op_reg;
    cb_v = mem_rdata;
    // pair select comes from the byte being decoded; op_reg still holds the prefix here
    ss_val = (mem_rdata[5:4] == 2'h3) ? sp_reg
             : {rf_reg[{mem_rdata[5:4], 1'b0}], rf_reg[{mem_rdata[5:4], 1'b1}]};
    if (state_reg == S_FETCH && pfx_reg == P_CB)
    begin
      cb_op = mem_rdata;
      cb_v = rf_reg[mem_rdata[2:0]];
    end
    if (phase_reg)
    begin
      case (state_reg)
        S_FETCH:
        begin
          if (pfx_reg == P_NONE && (mem_rdata[7:3] == GRP_SUB || mem_rdata[7:3] == GRP_XOR)
              && mem_rdata[2:0] != SEL_MEM)
          begin
            alu_fire = 1'b1;
            alu_op = (mem_rdata[7:3] == GRP_SUB) ? ALU_SUB : ALU_XOR;
            alu_b = rf_reg[mem_rdata[2:0]];
          end
          else if (pfx_reg == P_ED && mem_rdata[7:6] == 2'h0 && mem_rdata[2:0] == 3'h4
                   && mem_rdata[5:3] != SEL_MEM)
          begin
            alu_fire = 1'b1;
            alu_op = ALU_AND;
            alu_b = rf_reg[mem_rdata[5:3]];
          end
          else if (pfx_reg == P_IMM) alu_fire = 1'b1;
        end
        S_RDMEM: alu_fire = !cb_mem_reg;
        S_RDIO:
        begin
          alu_fire = 1'b1;
          alu_op = ALU_AND;
          alu_a = imm_reg;
          alu_b = port_rdata;
        end
        default: alu_fire = 1'b0;
      endcase
    end
    alu_q = alu8(alu_op, alu_a, alu_b);
    cb_q = cbop(cb_op, cb_v, f_reg);
    wsub = {1'b0, pair_pointer} - {1'b0, ss_val} - {16'h0000, f_reg[FL_C]};
    wsub_lo = {1'b0, pair_pointer[11:0]} - {1'b0, ss_val[11:0]} - {12'h000, f_reg[FL_C]};
  end

  // execution: decode on the sampled byte, update registers, pick next cycle
  always_ff @(posedge mclk)
  begin
    int_ack_pulse <= 1'b0;
    if (rst)
    begin
      state_reg <= S_FETCH;
      pfx_reg <= P_NONE;
      alu_reg <= ALU_SUB;
      pc_reg <= RST_PC;
      sp_reg <= RST_SP;
      f_reg <= RST_FLAGS;
      first_index_reg <= 16'h0000;
      second_index_reg <= 16'h0000;
      {cb_mem_reg, idx_hi_reg} <= 2'h0;
      {op_reg, imm_reg, disp_reg, wdat_reg} <= 32'h0;
      {ea_reg, vec_reg} <= 32'h0;
      for (int i = 0; i < 8; i++) rf_reg[i] <= 8'h00;
    end
    else if (phase_reg)
    begin
      if (alu_fire)
      begin
        f_reg <= alu_q[15:8];
        if (alu_op != ALU_AND) rf_reg[SEL_ACC] <= alu_q[7:0];
        state_reg <= S_FETCH;
      end
      case (state_reg)
        S_FETCH:
        begin
          pc_reg <= pc_reg + 16'h0001;
          pfx_reg <= P_NONE;
          op_reg <= mem_rdata;
          case (pfx_reg)
            P_NONE:
            begin
              if (mem_rdata == OP_CARRY_SET)
                f_reg <= (f_reg & ~(8'h01 << FL_H) & ~(8'h01 << FL_N)) | (8'h01 << FL_C);
              else if (mem_rdata == OP_SUB_IMM || mem_rdata == OP_XOR_IMM)
              begin
                pfx_reg <= P_IMM;
                alu_reg <= (mem_rdata == OP_SUB_IMM) ? ALU_SUB : ALU_XOR;
              end
              else if (mem_rdata == PFX_BIT) pfx_reg <= P_CB;
              else if (mem_rdata == PFX_EXT) pfx_reg <= P_ED;
              else if (mem_rdata == PFX_IDX_LO || mem_rdata == PFX_IDX_HI)
              begin
                pfx_reg <= P_IDX;
                idx_hi_reg <= mem_rdata[5];
              end
              else if ((mem_rdata[7:3] == GRP_SUB || mem_rdata[7:3] == GRP_XOR) && mem_rdata[2:0] == SEL_MEM)
              begin
                alu_reg <= (mem_rdata[7:3] == GRP_SUB) ? ALU_SUB : ALU_XOR;
                cb_mem_reg <= 1'b0;
                ea_reg <= pair_pointer;
                state_reg <= S_RDMEM;
              end
            end
            P_CB:
            begin
              if (mem_rdata[2:0] == SEL_MEM)
              begin
                cb_mem_reg <= 1'b1;
                ea_reg <= pair_pointer;
                state_reg <= S_RDMEM;
              end
              else
              begin
                rf_reg[mem_rdata[2:0]] <= cb_q[7:0];
                f_reg <= cb_q[15:8];
              end
            end
            P_ED:
            begin
              if (mem_rdata == OP_SLEEP) state_reg <= S_SLEEP;
              else if (mem_rdata == OP_TEST_IMM)
              begin
                pfx_reg <= P_IMM;
                alu_reg <= ALU_AND;
              end
              else if (mem_rdata == OP_PORT_TEST) pfx_reg <= P_TIO;
              else if (mem_rdata == 8'h34)
              begin
                alu_reg <= ALU_AND;
                cb_mem_reg <= 1'b0;
                ea_reg <= pair_pointer;
                state_reg <= S_RDMEM;
              end
              else if (mem_rdata[7:6] == 2'h1 && mem_rdata[3:0] == 4'h2)
              begin
                {rf_reg[SEL_H], rf_reg[SEL_L]} <= wsub[15:0];
                f_reg <= {wsub[15], (wsub[15:0] == 16'h0000), 1'b0, wsub_lo[12], 1'b0,
                          (pair_pointer[15] ^ ss_val[15]) & (pair_pointer[15] ^ wsub[15]), 1'b0, wsub[16]};
              end
            end
            P_TIO:
            begin
              imm_reg <= mem_rdata;
              state_reg <= S_RDIO;
            end
            P_IDX: if (mem_rdata == PFX_BIT) pfx_reg <= P_IDXCB;
            P_IDXCB:
            begin
              disp_reg <= mem_rdata;
              pfx_reg <= P_IDXOP;
            end
            P_IDXOP:
            begin
              cb_mem_reg <= 1'b1;
              ea_reg <= (idx_hi_reg ? second_index_reg : first_index_reg) + {{8{disp_reg[7]}}, disp_reg};
              state_reg <= S_RDMEM;
            end
            default: pfx_reg <= P_NONE;
          endcase
        end
        S_RDMEM:
        begin
          if (cb_mem_reg)
          begin
            wdat_reg <= cb_q[7:0];
            f_reg <= cb_q[15:8];
            state_reg <= S_WRMEM;
          end
        end
        S_SLEEP:
        begin
          if (nmi_lvl || (irq_lvl && int_enable))
          begin
            vec_reg <= nmi_lvl ? NMI_VECTOR : INT_VECTOR;
            state_reg <= S_PUSH_HI;
          end
          else if (irq_lvl) state_reg <= S_FETCH;
        end
        S_PUSH_HI: state_reg <= S_PUSH_LO;
        S_PUSH_LO:
        begin
          sp_reg <= sp_reg - 16'h0002;
          pc_reg <= vec_reg;
          int_ack_pulse <= 1'b1;
          state_reg <= S_FETCH;
        end
        S_WRMEM: state_reg <= S_FETCH;
        default: state_reg <= S_FETCH;
      endcase
    end
  end

  // bus drive: set at phase 0, strobe for the sampling clock
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {memory_address_bus, port_address_bus} <= 32'h0;
      {memory_write_bus, port_write_bus} <= 16'h0;
      {mem_rd_strobe, mem_wr_strobe, port_rd_strobe, sleep_out} <= 4'h0;
    end
    else if (phase_reg) {mem_rd_strobe, mem_wr_strobe, port_rd_strobe} <= 3'h0;
    else
    begin
      sleep_out <= (state_reg == S_SLEEP);
      mem_rd_strobe <= (state_reg == S_FETCH || state_reg == S_RDMEM);
      mem_wr_strobe <= (state_reg == S_WRMEM || state_reg == S_PUSH_HI || state_reg == S_PUSH_LO);
      port_rd_strobe <= (state_reg == S_RDIO);
      case (state_reg)
        S_FETCH: memory_address_bus <= pc_reg;
        S_RDMEM: memory_address_bus <= ea_reg;
        S_WRMEM:
        begin
          memory_address_bus <= ea_reg;
          memory_write_bus <= wdat_reg;
        end
        S_RDIO: port_address_bus <= {8'h00, rf_reg[SEL_C]};
        S_PUSH_HI:
        begin
          memory_address_bus <= sp_reg - 16'h0001;
          memory_write_bus <= pc_reg[15:8];
        end
        S_PUSH_LO:
        begin
          memory_address_bus <= sp_reg - 16'h0002;
          memory_write_bus <= pc_reg[7:0];
        end
        default:
        begin
          {memory_address_bus, port_address_bus} <= 32'h0;
          {memory_write_bus, port_write_bus} <= 16'h0;
        end
      endcase
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = state_reg == S_FETCH && phase_reg;
  wire [7:0] src_r = rf_reg[mem_rdata[2:0]];

  sleep_bus_a: assert property (sleep_out |-> memory_address_bus == 16'h0000
    && port_address_bus == 16'h0000 && memory_write_bus == 8'h00 && port_write_bus == 8'h00) else $error("bus not idle asleep");
  carry_set_a: assert property (take && pfx_reg == P_NONE && mem_rdata == OP_CARRY_SET |=>
    f_reg == (($past(f_reg) & 8'hed) | 8'h01) ##1 mem_rd_strobe && memory_address_bus == $past(pc_reg, 2) + 16'h0001)
    else $error("carry set wrong");
  bit_set_a: assert property (take && pfx_reg == P_CB && mem_rdata[7:6] == GRP_SET && mem_rdata[2:0] != SEL_MEM
    |=> rf_reg[$past(mem_rdata[2:0])] == ($past(src_r) | (8'h01 << $past(mem_rdata[5:3]))) && $stable(f_reg))
    else $error("bit set wrong");
  shift_left_a: assert property (take && pfx_reg == P_CB && mem_rdata[7:3] == GRP_SHL && mem_rdata[2:0] != SEL_MEM
    |=> rf_reg[$past(mem_rdata[2:0])] == {$past(src_r[6:0]), 1'b0} && f_reg[FL_C] == $past(src_r[7]))
    else $error("left shift wrong");
  shift_arith_a: assert property (take && pfx_reg == P_CB && mem_rdata[7:3] == GRP_SHA && mem_rdata[2:0] != SEL_MEM
    |=> rf_reg[$past(mem_rdata[2:0])] == {$past(src_r[7]), $past(src_r[7:1])} && f_reg[FL_C] == $past(src_r[0]))
    else $error("arithmetic right shift wrong");
  shift_zero_a: assert property (take && pfx_reg == P_CB && mem_rdata[7:3] == GRP_SHZ && mem_rdata[2:0] != SEL_MEM
    |=> rf_reg[$past(mem_rdata[2:0])] == {1'b0, $past(src_r[7:1])} && f_reg[FL_C] == $past(src_r[0]))
    else $error("logical right shift wrong");
  sub_acc_a: assert property (take && pfx_reg == P_NONE && mem_rdata[7:3] == GRP_SUB && mem_rdata[2:0] != SEL_MEM
    |=> rf_reg[SEL_ACC] == $past(rf_reg[SEL_ACC] - src_r) && f_reg[FL_C] == $past(rf_reg[SEL_ACC] < src_r))
    else $error("subtract wrong");
  test_keep_a: assert property (take && pfx_reg == P_ED && mem_rdata[7:6] == 2'h0 && mem_rdata[2:0] == 3'h4
    && mem_rdata[5:3] != SEL_MEM |=> $stable(rf_reg[SEL_ACC]) && f_reg[FL_H] && !f_reg[FL_C] && !f_reg[FL_N])
    else $error("test stored or bad flags");
  word_sub_a: assert property (take && pfx_reg == P_ED && mem_rdata == 8'h42
    |=> pair_pointer == $past(pair_pointer - {rf_reg[0], rf_reg[1]} - {15'h0000, f_reg[FL_C]}))
    else $error("word subtract wrong");
  wake_masked_a: assert property (state_reg == S_SLEEP && phase_reg && irq_lvl && !int_enable && !nmi_lvl
    |=> state_reg == S_FETCH ##1 !sleep_out && memory_address_bus == $past(pc_reg, 2)) else $error("no resume");
  wake_push_a: assert property (state_reg == S_SLEEP && phase_reg && nmi_lvl |=> ##1 mem_wr_strobe
    && memory_write_bus == $past(pc_reg[15:8], 2) ##2 memory_write_bus == $past(pc_reg[7:0], 4)) else $error("bad push");
  sleep_c: cover property (sleep_out ##1 !sleep_out);
  idx_set_c: cover property (state_reg == S_WRMEM && pfx_reg == P_NONE && idx_hi_reg);
  port_test_c: cover property (port_rd_strobe);
endmodule

/* File: bus_memory_model.sv */
/*
  Memory and port model for the execution slice: 256 bytes aliased over
  the whole address space and one port value set by the bench.
  Assumes the core's strobes are registered on mclk.
*/
`timescale 1ns/1ps
module bus_memory_model (
  input  wire logic        mclk,      // clock
  input  wire logic [15:0] mem_addr,  // memory address
  input  wire logic [7:0]  mem_wdata, // write data
  input  wire logic        mem_rd,    // read strobe
  input  wire logic        mem_wr,    // write strobe
  input  wire logic        port_rd,   // port read strobe
  output logic      [7:0]  mem_rdata, // read data
  output logic      [7:0]  port_rdata // port data
);
  logic [7:0] mem [0:255];
  logic [7:0] port_val;
  logic [7:0] last_mem_reg = 8'h00;
  logic [7:0] last_port_reg = 8'h00;
  // released lines show the inverse of the last byte, so stale data never matches
  assign mem_rdata  = mem_rd ? mem[mem_addr[7:0]] : ~last_mem_reg;
  assign port_rdata = port_rd ? port_val : ~last_port_reg;
  always @(posedge mclk)
  begin
    if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd) last_mem_reg <= mem_rdata;
    if (port_rd) last_port_reg <= port_rdata;
  end
endmodule

/* File: testbench.sv */
/*
  Self-checking bench: short programs go into the memory model, the core
  is reset and run, and results, bus activity and timing are compared.
  Assumes the memory model and the slice package.
*/
`timescale 1ns/1ps
module testbench;
  import cpu_slice_pkg::*;
  localparam logic [15:0] nmi_vec = 16'h0080;
  localparam logic [15:0] int_vec = 16'h0090;
  logic        mclk, rst, irq_pin, nmi_pin, int_enable, ack_seen, mem_rd_strobe, mem_wr_strobe;
  logic        port_rd_strobe, sleep_out, int_ack_pulse;
  logic [7:0]  mem_rdata, port_rdata, memory_write_bus, port_write_bus, acc_out, flags_out;
  logic [15:0] memory_address_bus, port_address_bus;
  logic [31:0] lfsr_reg;
  logic [7:0]  prog [$];
  logic [7:0]  a, b, e, f;
  logic [8:0]  s;
  logic [7:0]  sh_op [3] = '{8'h27, 8'h2f, 8'h3f};
  int          mismatches, checked;

  cpu_shift_logic_subtract_ops #(.NMI_VECTOR(nmi_vec), .INT_VECTOR(int_vec)) u_dut (
    .mclk(mclk), .rst(rst), .mem_rdata(mem_rdata), .port_rdata(port_rdata), .irq_pin(irq_pin),
    .nmi_pin(nmi_pin), .int_enable(int_enable), .memory_address_bus(memory_address_bus),
    .memory_write_bus(memory_write_bus), .mem_rd_strobe(mem_rd_strobe), .mem_wr_strobe(mem_wr_strobe),
    .port_address_bus(port_address_bus), .port_write_bus(port_write_bus),
    .port_rd_strobe(port_rd_strobe), .sleep_out(sleep_out), .int_ack_pulse(int_ack_pulse),
    .acc_out(acc_out), .flags_out(flags_out));
  bus_memory_model u_mem (
    .mclk(mclk), .mem_addr(memory_address_bus), .mem_wdata(memory_write_bus), .mem_rd(mem_rd_strobe),
    .mem_wr(mem_wr_strobe), .port_rd(port_rd_strobe), .mem_rdata(mem_rdata), .port_rdata(port_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg[7:0];
  endfunction
  function automatic logic [7:0] flg(input logic [7:0] v, input logic h, pv, c);
    return {v[7], v == 8'h00, 1'b0, h, 1'b0, pv, 1'b0, c};
  endfunction
  function automatic logic [7:0] sub_flags(input logic [7:0] x, y);
    logic [7:0] d;
    d = x - y;
    return flg(d, x[3:0] < y[3:0], (x[7] != y[7]) && (d[7] != x[7]), x < y);
  endfunction
  // result {carry, value} of the three shifts, by table index
  function automatic logic [8:0] shift(input int k, input logic [7:0] x);
    if (k == 0) return {x, 1'b0};
    if (k == 1) return {x[0], x[7], x[7:1]};
    return {x[0], 1'b0, x[7:1]};
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic timeout();
    $display("wait limit reached at %0t", $time);
    mismatches++;
    results();
  endtask
  task automatic cmp_word(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp(input logic [7:0] got, exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic start();
    for (int i = 0; i < 32; i++) u_mem.mem[i] = (i < prog.size()) ? prog[i] : 8'h00;
    rst = 1'b1;
    repeat (20) step();
    rst = 1'b0;
  endtask
  // waits for the fetch of addr; clk > 0 checks the clocks spent since reset
  task automatic wait_fetch(input logic [15:0] addr, input int clk);
    int n;
    n = 0;
    ack_seen = 1'b0;
    do
    begin
      step();
      n++;
      if (int_ack_pulse === 1'b1) ack_seen = 1'b1;
      if (port_rd_strobe === 1'b1) cmp_word(port_address_bus, 16'h0000);
    end
    while (!(mem_rd_strobe === 1'b1 && memory_address_bus === addr) && n < 600);
    if (n >= 600) timeout();
    if (clk > 0) cmp_word(16'(n), 16'(clk + 1));
    repeat (2) step();
  endtask
  task automatic go(input int clk);
    start();
    wait_fetch(16'(prog.size()), clk);
  endtask

  initial
  begin
    mismatches = 0;
    checked = 0;
    lfsr_reg = 32'hbebb96c0;
    {rst, irq_pin, nmi_pin, int_enable} = 4'b1000;
    for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'h00;
    u_mem.port_val = 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      // first two passes: overflow and half borrow corners
      a = (i < 2) ? 8'h80 >> (3 * i) : rnd();
      b = (i < 2) ? 8'h01 : rnd();
      prog = '{8'hee, a};
      go(4);
      cmp(acc_out, a);
      cmp(flags_out, flg(a, 1'b0, ~^a, 1'b0));
      prog = '{8'hee, a, 8'hd6, b};
      go(8);
      cmp(acc_out, a - b);
      cmp(flags_out, sub_flags(a, b));
      prog = '{8'hee, a, 8'h37};
      go(6);
      cmp(flags_out, flg(a, 1'b0, ~^a, 1'b1));
      prog = '{8'hee, a, 8'hcb, {2'b11, b[2:0], 3'h0}, 8'h90};
      go(10);
      e = 8'h01 << b[2:0];
      cmp(acc_out, a - e);
      cmp(flags_out, sub_flags(a, e));
      for (int k = 0; k < 3; k++)
      begin
        prog = '{8'hee, a, 8'hcb, sh_op[k]};
        go(8);
        s = shift(k, a);
        cmp(acc_out, s[7:0]);
        cmp(flags_out, flg(s[7:0], 1'b0, ~^s[7:0], s[8]));
      end
    end
    $display("test arithmetic and shifts done");
    for (int j = 0; j < 8; j++)
    begin
      if (j == 6) continue;
      a = rnd();
      b = rnd() & 8'h07;
      prog = '{8'hee, a, 8'hcb, {2'b11, b[2:0], 3'(j)}};
      if (j != 7) prog.push_back({5'h15, 3'(j)});
      go((j == 7) ? 8 : 10);
      e = (j == 7) ? (a | (8'h01 << b)) : (a ^ (8'h01 << b));
      f = (j == 7) ? a : e;
      cmp(acc_out, e);
      cmp(flags_out, flg(f, 1'b0, ~^f, 1'b0));
    end
    for (int y = 0; y < 2; y++)
    begin
      e = 8'h40 | (rnd() & 8'h3f);
      a = rnd();
      b = rnd() & 8'h07;
      u_mem.mem[e] = a;
      prog = '{(y == 1) ? 8'hfd : 8'hdd, 8'hcb, e, {2'b11, b[2:0], 3'h6}};
      go(12);
      cmp(u_mem.mem[e], a | (8'h01 << b));
      cmp(flags_out, 8'h00);
    end
    $display("test bit set done");
    a = rnd();
    b = rnd();
    u_mem.port_val = rnd();
    prog = '{8'hee, a, 8'hed, 8'h64, b};
    go(10);
    cmp(acc_out, a);
    cmp(flags_out, flg(a & b, 1'b1, ~^(a & b), 1'b0));
    prog = '{8'hee, a, 8'hed, 8'h3c};
    go(8);
    cmp(flags_out, flg(a, 1'b1, ~^a, 1'b0));
    // pointer pair is zero after reset, so the memory operand is the first program byte
    prog = '{8'hee, a, 8'hed, 8'h34};
    go(10);
    e = a & 8'hee;
    cmp(acc_out, a);
    cmp(flags_out, flg(e, 1'b1, ~^e, 1'b0));
    prog = '{8'hee, a, 8'hed, 8'h74, b};
    go(12);
    e = u_mem.port_val & b;
    cmp(acc_out, a);
    cmp(flags_out, flg(e, 1'b1, ~^e, 1'b0));
    $display("test and-test done");
    u_mem.mem[8'hff] = rnd();
    prog = '{8'hed, 8'h42};
    go(4);
    cmp(flags_out, 8'h40);
    prog = '{8'h37, 8'hed, 8'h42};
    go(6);
    cmp(flags_out, 8'h91);
    // c = 1 makes the pair select matter: 0 - 1 leaves the pointer at ffff
    prog = '{8'hcb, 8'hc1, 8'hed, 8'h42, 8'hae};
    go(12);
    cmp(acc_out, u_mem.mem[8'hff]);
    $display("test word subtract done");
    for (int m = 0; m < 3; m++)
    begin
      a = rnd();
      u_mem.mem[8'hfe] = 8'h5a;
      u_mem.mem[8'hff] = 8'h5a;
      prog = '{8'hee, a, 8'hed, 8'h76};
      int_enable = (m == 1);
      start();
      for (int i = 0; i < 40 && sleep_out !== 1'b1; i++) step();
      if (sleep_out !== 1'b1) timeout();
      repeat (4)
      begin
        step();
        cmp(memory_write_bus | port_write_bus, 8'h00);
        cmp_word(memory_address_bus | port_address_bus, 16'h0000);
      end
      irq_pin = (m < 2);
      nmi_pin = (m == 2);
      wait_fetch((m == 0) ? 16'h0004 : (m == 1) ? int_vec : nmi_vec, 0);
      {irq_pin, nmi_pin} = 2'b00;
      cmp({7'h00, ack_seen}, {7'h00, m != 0});
      cmp(acc_out, a);
      cmp(flags_out, flg(a, 1'b0, ~^a, 1'b0));
      if (m != 0) cmp_word({u_mem.mem[8'hff], u_mem.mem[8'hfe]}, 16'h0004);
    end
    $display("test sleep done");
    results();
  end
endmodule
